// [hw/dlcirq_defines.svh]
// constants for the dual loadable counter block
// What this block does
// - two 8-bit up-counters, limits 0x3f and 0x1f
// - reset clears, enable high lets counting proceed
// - both counters start from zero after power-up
// - counter one irq line zero, two line one
// - terminal count drives carry-out low, raising irq
// - active-low request held at least three cycles
// - strobe plus select loads data bus value
// - after release, count up from loaded value
// - irq zero: tally, store 0x0f9b, reload counter one
// - irq zero: multiply tallies, store 0x0f9d/0x0f9e
// - irq one: tally, store 0x0f9c, reload counter two
`ifndef DLCIRQ_DEFINES_SVH
`define DLCIRQ_DEFINES_SVH
`define DLCIRQ_WIDTH 8
`define DLCIRQ_LIMIT_ONE 8'h3f
`define DLCIRQ_LIMIT_TWO 8'h1f
`define DLCIRQ_IRQ_HOLD 2'h3
`define DLCIRQ_SEL_ONE 2'h1
`define DLCIRQ_SEL_TWO 2'h2
`define DLCIRQ_ADDR_TALLY_ONE 16'h0f9b
`define DLCIRQ_ADDR_TALLY_TWO 16'h0f9c
`define DLCIRQ_ADDR_PROD_LO 16'h0f9d
`define DLCIRQ_ADDR_PROD_HI 16'h0f9e
`endif

// [hw/dlcirq_pkg.sv]
// types shared by the dual counter block
package dlcirq_pkg;
  typedef enum logic [2:0] {
    DLCIRQ_IDLE = 3'h0,
    DLCIRQ_SERVE = 3'h1,
    DLCIRQ_LOAD = 3'h3,
    DLCIRQ_WAIT = 3'h2,
    DLCIRQ_DROP = 3'h6
  } dlcirq_host_state_t;
endpackage

// [hw/dlcirq_link_if.sv]
// link between the counter block and the processor end
interface dlcirq_link_if;
  logic host_write_strobe;
  logic [1:0] io_select;
  logic [7:0] data_bus;
  logic counter_one_irq_line;
  logic counter_two_irq_line;
  modport device (input host_write_strobe, input io_select, input data_bus,
    output counter_one_irq_line, output counter_two_irq_line);
  modport host (output host_write_strobe, output io_select, output data_bus,
    input counter_one_irq_line, input counter_two_irq_line);
endinterface

// [hw/dlcirq_counter.sv]
// one loadable up-counter with held active-low carry-out
`include "dlcirq_defines.svh"
module dlcirq_counter #(
  parameter int WIDTH = `DLCIRQ_WIDTH,
  parameter logic [WIDTH-1:0] LIMIT = `DLCIRQ_LIMIT_ONE
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_count,
  output logic o_terminal_carry_out_n
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic carry_n;
    logic [1:0] hold;
  } dlcirq_cnt_state_t;
  dlcirq_cnt_state_t st, next_st;

  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.count = i_data;
    end else if (i_enable) begin
      // wraps to zero past the limit; load has priority over counting
      next_st.count = (st.count >= LIMIT) ? '0 : WIDTH'(st.count + 1'b1);
    end
    if (st.hold != 2'h0) begin
      // request must stand long enough for the processor to see it
      next_st.hold = 2'(st.hold - 2'h1);
    end else if (!st.carry_n && (i_load || next_st.count != LIMIT)) begin
      next_st.carry_n = 1'b1;
    end
    if (st.carry_n && next_st.count == LIMIT && !i_load) begin
      next_st.carry_n = 1'b0;
      next_st.hold = `DLCIRQ_IRQ_HOLD - 2'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '{count: '0, carry_n: 1'b1, hold: 2'h0};
    end else begin
      st <= next_st;
    end
  end

  assign o_count = st.count;
  assign o_terminal_carry_out_n = st.carry_n;
endmodule

// [hw/dlcirq_device.sv]
// device end: two loadable counters driving the irq lines
`include "dlcirq_defines.svh"
module dlcirq_device (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  dlcirq_link_if.device link,
  output logic [7:0] o_count_one,
  output logic [7:0] o_count_two
);
  logic load_one;
  logic load_two;
  assign load_one = link.host_write_strobe && link.io_select[0];
  assign load_two = link.host_write_strobe && link.io_select[1];

  // ************
  // counters
  // ************
  dlcirq_counter #(.WIDTH(`DLCIRQ_WIDTH), .LIMIT(`DLCIRQ_LIMIT_ONE)) u_one (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_load(load_one),
    .i_data(link.data_bus), .o_count(o_count_one),
    .o_terminal_carry_out_n(link.counter_one_irq_line));
  dlcirq_counter #(.WIDTH(`DLCIRQ_WIDTH), .LIMIT(`DLCIRQ_LIMIT_TWO)) u_two (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_load(load_two),
    .i_data(link.data_bus), .o_count(o_count_two),
    .o_terminal_carry_out_n(link.counter_two_irq_line));
endmodule

// [hw/dlcirq_host.sv]
// processor end: services both irq lines, tallies, multiplies, reloads
`include "dlcirq_defines.svh"
module dlcirq_host (
  input wire logic i_clock,
  input wire logic i_rst,
  dlcirq_link_if.host link,
  output logic o_mem_write,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_data,
  output logic [7:0] o_tally_one,
  output logic [7:0] o_tally_two,
  output logic [15:0] o_product
);
  typedef struct packed {
    dlcirq_pkg::dlcirq_host_state_t fsm;
    logic [1:0] seen_one;
    logic [1:0] seen_two;
    logic pend_one;
    logic pend_two;
    logic which;
    logic [1:0] step;
    logic [7:0] tally_one;
    logic [7:0] tally_two;
    logic [15:0] product;
    logic strobe;
    logic [1:0] sel;
    logic [7:0] data;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_data;
  } dlcirq_host_st_t;
  dlcirq_host_st_t st, next_st;

  function automatic logic [1:0] seen_step(input logic line_n, input logic [1:0] seen);
    if (line_n) begin
      seen_step = 2'h0;
    end else if (seen == `DLCIRQ_IRQ_HOLD) begin
      seen_step = seen;
    end else begin
      seen_step = 2'(seen + 2'h1);
    end
  endfunction

  always_comb begin
    next_st = st;
    next_st.mem_we = 1'b0;
    // a request counts only after it has been low for three samples
    next_st.seen_one = seen_step(link.counter_one_irq_line, st.seen_one);
    next_st.seen_two = seen_step(link.counter_two_irq_line, st.seen_two);
    case (st.fsm)
      dlcirq_pkg::DLCIRQ_IDLE: begin
        if (st.pend_one) begin
          next_st.pend_one = 1'b0;
          next_st.which = 1'b0;
          next_st.tally_one = 8'(st.tally_one + 8'h01);
          next_st.step = 2'h0;
          next_st.fsm = dlcirq_pkg::DLCIRQ_SERVE;
        end else if (st.pend_two) begin
          next_st.pend_two = 1'b0;
          next_st.which = 1'b1;
          next_st.tally_two = 8'(st.tally_two + 8'h01);
          next_st.step = 2'h0;
          next_st.fsm = dlcirq_pkg::DLCIRQ_SERVE;
        end
      end
      dlcirq_pkg::DLCIRQ_SERVE: begin
        next_st.mem_we = 1'b1;
        next_st.step = 2'(st.step + 2'h1);
        if (st.which) begin
          next_st.mem_addr = `DLCIRQ_ADDR_TALLY_TWO;
          next_st.mem_data = st.tally_two;
          next_st.fsm = dlcirq_pkg::DLCIRQ_LOAD;
        end else begin
          case (st.step)
            2'h0: begin
              next_st.mem_addr = `DLCIRQ_ADDR_TALLY_ONE;
              next_st.mem_data = st.tally_one;
              next_st.product = 16'(st.tally_one) * 16'(st.tally_two);
            end
            2'h1: begin
              next_st.mem_addr = `DLCIRQ_ADDR_PROD_LO;
              next_st.mem_data = st.product[7:0];
            end
            default: begin
              next_st.mem_addr = `DLCIRQ_ADDR_PROD_HI;
              next_st.mem_data = st.product[15:8];
              next_st.fsm = dlcirq_pkg::DLCIRQ_LOAD;
            end
          endcase
        end
      end
      dlcirq_pkg::DLCIRQ_LOAD: begin
        next_st.strobe = 1'b1;
        next_st.sel = st.which ? `DLCIRQ_SEL_TWO : `DLCIRQ_SEL_ONE;
        next_st.data = st.which ? st.tally_two : st.tally_one;
        next_st.fsm = dlcirq_pkg::DLCIRQ_WAIT;
      end
      dlcirq_pkg::DLCIRQ_WAIT: begin
        next_st.strobe = 1'b0;
        next_st.sel = 2'h0;
        next_st.fsm = dlcirq_pkg::DLCIRQ_DROP;
      end
      dlcirq_pkg::DLCIRQ_DROP: begin
        // wait for the serviced line to go high so one event is not served twice
        if (st.which ? link.counter_two_irq_line : link.counter_one_irq_line) begin
          next_st.fsm = dlcirq_pkg::DLCIRQ_IDLE;
        end
      end
      default: next_st.fsm = dlcirq_pkg::DLCIRQ_IDLE;
    endcase
    // the line is released the cycle it is recognised, so a request seen while busy is latched
    if (next_st.seen_one == `DLCIRQ_IRQ_HOLD && st.seen_one != `DLCIRQ_IRQ_HOLD) begin
      next_st.pend_one = 1'b1;
    end
    if (next_st.seen_two == `DLCIRQ_IRQ_HOLD && st.seen_two != `DLCIRQ_IRQ_HOLD) begin
      next_st.pend_two = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.host_write_strobe = st.strobe;
  assign link.io_select = st.sel;
  assign link.data_bus = st.data;
  assign o_mem_write = st.mem_we;
  assign o_mem_addr = st.mem_addr;
  assign o_mem_data = st.mem_data;
  assign o_tally_one = st.tally_one;
  assign o_tally_two = st.tally_two;
  assign o_product = st.product;
endmodule

// [verification/dlcirq_chk.sv]
// checker for the link between the counter block and the processor end
// ************
// link checks
// ************
module dlcirq_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic host_write_strobe,
  input wire logic [1:0] io_select,
  input wire logic [7:0] data_bus,
  input wire logic counter_one_irq_line,
  input wire logic counter_two_irq_line
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence load_one_s;
    host_write_strobe && io_select == 2'h1;
  endsequence
  sequence load_two_s;
    host_write_strobe && io_select == 2'h2;
  endsequence
  sequence request_one_s;
    $fell(counter_one_irq_line);
  endsequence
  sequence request_two_s;
    $fell(counter_two_irq_line);
  endsequence
  hold_one_a: assert property ($fell(counter_one_irq_line) |-> !counter_one_irq_line [*3])
    else $error("irq line one released early");
  hold_two_a: assert property ($fell(counter_two_irq_line) |-> !counter_two_irq_line [*3])
    else $error("irq line two released early");
  // the line is already released when the reload comes; the windows allow a busy host four extra cycles on line one, six on line two
  serve_one_a: assert property (request_one_s |-> ##[8:12] load_one_s)
    else $error("irq line one not served by a reload");
  serve_two_a: assert property (request_two_s |-> ##[6:12] load_two_s)
    else $error("irq line two not served by a reload");
  load_data_one_a: assert property (load_one_s |-> data_bus != 8'h00)
    else $error("counter one reloaded with an empty tally");
  load_data_two_a: assert property (load_two_s |-> data_bus != 8'h00)
    else $error("counter two reloaded with an empty tally");
  // eight quiet cycles: a reload far below the limit cannot reach it sooner
  reload_one_a: assert property (load_one_s |=> counter_one_irq_line [*8])
    else $error("irq line one not released by reload");
  reload_two_a: assert property (load_two_s |=> counter_two_irq_line [*8])
    else $error("irq line two not released by reload");
  strobe_pulse_a: assert property (host_write_strobe |=> !host_write_strobe)
    else $error("write strobe held too long");
  idle_select_a: assert property (!host_write_strobe |-> io_select == 2'h0)
    else $error("select active without strobe");
endmodule

// [verification/tb.sv]
// self-checking bench joining both ends of the counter link
// ************
// bench
// ************
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst, i_enable, mem_wr;
  logic [15:0] mem_addr, product;
  logic [7:0] mem_data, c1, c2, t1, t2;
  logic [7:0] mem [0:65535];
  int n_mismatch = 0;
  int checks = 0;
  int k;
  dlcirq_link_if link ();
  dlcirq_device u_dlcirq_device (.i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .link(link.device),
    .o_count_one(c1), .o_count_two(c2));
  dlcirq_host u_dlcirq_host (.i_clock(i_clock), .i_rst(i_rst), .link(link.host), .o_mem_write(mem_wr),
    .o_mem_addr(mem_addr), .o_mem_data(mem_data), .o_tally_one(t1), .o_tally_two(t2), .o_product(product));
  dlcirq_chk u_dlcirq_chk (.i_clock(i_clock), .i_rst(i_rst), .host_write_strobe(link.host_write_strobe),
    .io_select(link.io_select), .data_bus(link.data_bus), .counter_one_irq_line(link.counter_one_irq_line),
    .counter_two_irq_line(link.counter_two_irq_line));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // shared memory modelled as a capture of the host's write port
  always @(posedge i_clock) begin
    if (mem_wr === 1'b1) mem[mem_addr] = mem_data;
  end
  task step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // whole run is some ninety cycles, so three thousand is ample
  initial begin
    #30000;
    n_mismatch++;
    close_out();
  end
  initial begin
    i_rst = 1'b1;
    i_enable = 1'b0;
    step(4);
    i_rst = 1'b0;
    step(5);
    chk("count one idle", 16'h0000, {8'h00, c1});
    i_enable = 1'b1;
    for (k = 0; k < 100 && link.counter_two_irq_line !== 1'b0; k++) step(1);
    chk("count two limit", 16'h001f, {8'h00, c2});
    chk("count one from zero", 16'h001f, {8'h00, c1});
    chk("line one idle", 16'h0001, {15'h0000, link.counter_one_irq_line});
    for (k = 0; k < 100 && link.counter_one_irq_line !== 1'b0; k++) step(1);
    chk("count one limit", 16'h003f, {8'h00, c1});
    chk("tally two", 16'h0001, {8'h00, t2});
    chk("count two reloaded", 16'h001a, {8'h00, c2});
    chk("mem tally two", 16'h0001, {8'h00, mem[16'h0f9c]});
    step(12);
    chk("tally one", 16'h0001, {8'h00, t1});
    chk("mem tally one", 16'h0001, {8'h00, mem[16'h0f9b]});
    chk("product", 16'h0001, product);
    chk("mem product lo", 16'h0001, {8'h00, mem[16'h0f9d]});
    chk("mem product hi", 16'h0000, {8'h00, mem[16'h0f9e]});
    chk("line one released", 16'h0001, {15'h0000, link.counter_one_irq_line});
    chk("count one reloaded", 16'h0004, {8'h00, c1});
    chk("tally two again", 16'h0002, {8'h00, t2});
    i_rst = 1'b1;
    step(1);
    chk("reset counts", 16'h0000, {c1, c2});
    chk("reset line two", 16'h0001, {15'h0000, link.counter_two_irq_line});
    i_rst = 1'b0;
    step(2);
    close_out();
  end
endmodule
